/* ite_pkg.sv */
// Package of constants for the input trigger and expansion select block
package ite_pkg;

   // -----------------------------------------------------------------
   // Channel addressing
   // -----------------------------------------------------------------
   localparam int          CHAN_W       = 9;
   localparam int          EXP_SEL_W    = 5;
   localparam int          EXP_SEL_LSB  = 4;
   localparam int          BOARD_LINES  = 64;
   localparam int          MAX_BOARDS   = 8;

   // -----------------------------------------------------------------
   // Trigger modes and reset values
   // -----------------------------------------------------------------
   localparam logic [1:0]  TRIG_NONE    = 2'h0;
   localparam logic [1:0]  TRIG_ONESHOT = 2'h1;
   localparam logic [1:0]  TRIG_GATED   = 2'h2;
   localparam logic [15:0] DAC_ZERO     = 16'h8000;

   typedef enum logic [1:0]
   {
      ITE_IDLE,
      ITE_ARM,
      ITE_WAIT,
      ITE_RUN
   } ite_state_e;

endpackage : ite_pkg

/* ite_trigger_select.sv */
// Expansion select, external trigger gating and sample clock echo
`timescale 1ns/1ps
// Summary of operation
// - Upper five channel bits on select lines
// - Select set one sample period early
// - Eight boards of sixty-four lines addressable
// - Trigger active high, inactive start holds off
// - Held-off sampling starts on rising trigger
// - One-shot or gated mode from configuration
// - No trigger configuration ignores trigger input
// - Undriven trigger reads as active
// - Buffered internal sample clock driven out
// - Both converters load zero code at reset
module ite_trigger_select #(
   parameter int CHAN_W = ite_pkg::CHAN_W
)(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              proc_start,
   input  wire logic              proc_stop,
   input  wire logic [1:0]        hardware_trigger_config,
   input  wire logic              ext_input_trigger_pin,
   input  wire logic              ext_input_trigger_driven,
   input  wire logic              sample_tick,
   input  wire logic [CHAN_W-1:0] next_chan,
   output logic [4:0]             exp_sel,
   output logic                   sample_en,
   output logic                   internal_sample_clock_out,
   output logic [15:0]            dac0_code,
   output logic [15:0]            dac1_code,
   output logic                   running
);

   // -----------------------------------------------------------------
   // Trigger synchroniser
   // -----------------------------------------------------------------
   logic       trig_raw;
   logic [2:0] sync_r;
   logic [2:0] sync_nxt;

   // Floating pin is pulled to the active level
   assign trig_raw = ext_input_trigger_driven ? ext_input_trigger_pin
                                              : 1'b1;

   always_comb
   begin
      // Stage 0 feeds only stage 1
      sync_nxt = {sync_r[1], sync_r[0], trig_raw};
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         sync_r <= 3'h7;
      else
         sync_r <= sync_nxt;
   end

   logic trig_lvl;
   logic trig_rise;
   assign trig_lvl  = sync_r[1];
   assign trig_rise = sync_r[1] & ~sync_r[2];

   // -----------------------------------------------------------------
   // Trigger state machine
   // -----------------------------------------------------------------
   ite_pkg::ite_state_e state_r;
   ite_pkg::ite_state_e state_nxt;
   logic [1:0]          mode_r;
   logic [1:0]          mode_nxt;

   always_comb
   begin
      state_nxt = state_r;
      mode_nxt  = mode_r;
      case (state_r)
         ite_pkg::ITE_IDLE:
         begin
            if (proc_start)
            begin
               mode_nxt = hardware_trigger_config;
               if (hardware_trigger_config == ite_pkg::TRIG_NONE)
                  state_nxt = ite_pkg::ITE_RUN;
               else if (trig_lvl)
                  state_nxt = ite_pkg::ITE_RUN;
               else
                  state_nxt = ite_pkg::ITE_WAIT;
            end
         end
         ite_pkg::ITE_WAIT:
         begin
            if (trig_rise)
               state_nxt = ite_pkg::ITE_RUN;
         end
         ite_pkg::ITE_RUN:
         begin
            // Gated mode waits again for the next rising edge
            if (mode_r == ite_pkg::TRIG_GATED && !trig_lvl)
               state_nxt = ite_pkg::ITE_WAIT;
         end
         default:
            state_nxt = ite_pkg::ITE_IDLE;
      endcase
      if (proc_stop)
         state_nxt = ite_pkg::ITE_IDLE;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ite_pkg::ITE_IDLE;
         mode_r  <= ite_pkg::TRIG_NONE;
      end
      else
      begin
         state_r <= state_nxt;
         mode_r  <= mode_nxt;
      end
   end

   assign running = (state_r == ite_pkg::ITE_RUN);

   // Sample only while running; one-shot ignores later levels
   assign sample_en = running & sample_tick;

   // -----------------------------------------------------------------
   // Expansion select and clock echo
   // -----------------------------------------------------------------
   logic [4:0] sel_r;
   logic [4:0] sel_nxt;
   logic       clk_r;
   logic       clk_nxt;

   // One select line per upper channel bit; line 4 carries the MSB
   logic [4:0] chan_hi;

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_sel_bit
         assign chan_hi[gi] = next_chan[ite_pkg::EXP_SEL_LSB + gi];
      end
   endgenerate

   always_comb
   begin
      sel_nxt = sel_r;
      // Next channel is latched on the tick before its conversion, so
      // it stands one full period and through the sampling edge
      if (sample_tick)
         sel_nxt = chan_hi;
      clk_nxt = sample_en;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_r <= 5'h0;
         clk_r <= 1'b0;
      end
      else
      begin
         sel_r <= sel_nxt;
         clk_r <= clk_nxt;
      end
   end

   assign exp_sel                   = sel_r;
   assign internal_sample_clock_out = clk_r;

   // Converters hold the zero code from reset onward
   assign dac0_code = ite_pkg::DAC_ZERO;
   assign dac1_code = ite_pkg::DAC_ZERO;

endmodule : ite_trigger_select

/* ite_props.sv */
// Checker for the trigger and expansion select block
`timescale 1ns/1ps
module ite_props #(parameter int CHAN_W = ite_pkg::CHAN_W)(
input wire logic ref_clk,
input wire logic rst_n,
input wire logic proc_start,
input wire logic proc_stop,
input wire logic [1:0] hardware_trigger_config,
input wire logic ext_input_trigger_pin,
input wire logic ext_input_trigger_driven,
input wire logic sample_tick,
input wire logic [CHAN_W-1:0] next_chan,
input wire logic [4:0] exp_sel,
input wire logic sample_en,
input wire logic internal_sample_clock_out,
input wire logic [15:0] dac0_code,
input wire logic [15:0] dac1_code,
input wire logic running);
logic trg, gate_r, shot_r;
// Undriven trigger counts as active
assign trg = ext_input_trigger_pin | ~ext_input_trigger_driven;
always_ff @(posedge ref_clk or negedge rst_n)
if (!rst_n) {gate_r, shot_r} <= 2'b00;
else if (proc_stop) {gate_r, shot_r} <= 2'b00;
else if (proc_start) {gate_r, shot_r} <= {hardware_trigger_config ==
ite_pkg::TRIG_GATED, hardware_trigger_config == ite_pkg::TRIG_ONESHOT};
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_n);
sequence s_arm;
!trg[*3] ##0 proc_stop ##1 proc_start && !trg &&
hardware_trigger_config != ite_pkg::TRIG_NONE;
endsequence
AST_SEL: assert property (sample_tick |=>
exp_sel == $past(next_chan[CHAN_W-1-:5])) else $error("sel");
AST_CLK: assert property (sample_tick && running |->
sample_en ##1 internal_sample_clock_out) else $error("clk");
AST_DAC: assert property (dac0_code == 16'h8000 &&
dac1_code == 16'h8000) else $error("dac");
AST_NONE: assert property (proc_stop ##1 proc_start &&
hardware_trigger_config == ite_pkg::TRIG_NONE |=> running) else $error("none");
AST_HOLD: assert property (s_arm |=> !running) else $error("hold");
AST_RISE: assert property (s_arm ##1 (trg && !proc_stop)[*4] |->
running) else $error("rise");
AST_GATE: assert property ((gate_r && !trg)[*5] |->
!running) else $error("gate");
AST_SHOT: assert property (shot_r && running && !proc_stop |=>
running) else $error("shot");
endmodule : ite_props
bind ite_trigger_select ite_props #(.CHAN_W(CHAN_W)) u_props (.*);

/* ite_trig_src.sv */
// Trigger source model on the external trigger pin
`timescale 1ns/1ps
module ite_trig_src (
input wire logic ref_clk,
input wire logic level,
input wire logic drive,
output logic pin,
output logic driven);
logic flip = 1'b0;
// Released line toggles so a read of the floating pin shows up
always @(posedge ref_clk) flip <= ~flip;
assign driven = drive;
assign pin = drive ? level : flip;
endmodule : ite_trig_src

/* input_trigger_expansion_select_bench.sv */
// Testbench for the trigger and expansion select block
`timescale 1ns/1ps
module input_trigger_expansion_select_bench;
logic ref_clk = 0, rst_n = 0, proc_start = 0, proc_stop = 0, tick = 0;
logic lvl = 0, drv = 1, pin, driven, en, ck, run;
logic [1:0] cfg = 2'h0;
logic [8:0] chan = 9'h000;
logic [8:0] ch [2] = '{9'h0A5, 9'h1F3};
logic [4:0] sel;
logic [15:0] d0, d1;
int mismatches = 0, total_checks = 0, cycles = 0;
ite_trig_src src (.ref_clk(ref_clk), .level(lvl), .drive(drv), .pin(pin),
.driven(driven));
ite_trigger_select dut (.ref_clk(ref_clk), .rst_n(rst_n),
.proc_start(proc_start), .proc_stop(proc_stop),
.hardware_trigger_config(cfg), .ext_input_trigger_pin(pin),
.ext_input_trigger_driven(driven), .sample_tick(tick), .next_chan(chan),
.exp_sel(sel), .sample_en(en), .internal_sample_clock_out(ck),
.dac0_code(d0), .dac1_code(d1), .running(run));
initial forever #4 ref_clk = ~ref_clk;
task close_out();
if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
else $display("DONE - FAIL");
$finish;
endtask : close_out
always @(posedge ref_clk)
if (++cycles == 3000) begin mismatches++; close_out(); end
task chk(logic [15:0] seen, logic [15:0] exp);
total_checks++;
if (seen !== exp) begin mismatches++;
$display("wrong value at %0t: %h %h", $time, seen, exp); end
endtask : chk
task cyc(int n); repeat (n) @(posedge ref_clk); endtask : cyc
task go(logic [1:0] c);
@(posedge ref_clk) proc_stop <= 1;
@(posedge ref_clk) {proc_stop, proc_start, cfg} <= {2'b01, c};
@(posedge ref_clk) proc_start <= 0;
@(negedge ref_clk);
endtask : go
task rise_fall(logic v, int n, logic r);
@(posedge ref_clk) lvl <= v;
cyc(n);
@(negedge ref_clk) chk(run, r);
endtask : rise_fall
initial begin
cyc(10);
rst_n <= 1;
go(ite_pkg::TRIG_NONE);
chk(run, 1);
foreach (ch[i]) begin
@(posedge ref_clk) {tick, chan} <= {1'b1, ch[i]};
@(negedge ref_clk) chk(en, 1);
if (i > 0) chk(sel, ch[i-1][8:4]);
end
@(posedge ref_clk) tick <= 0;
@(negedge ref_clk) chk(sel, 5'h1F);
chk(ck, 1);
chk(d0, ite_pkg::DAC_ZERO);
chk(d1, ite_pkg::DAC_ZERO);
go(ite_pkg::TRIG_ONESHOT);
chk(run, 0);
rise_fall(1, 4, 1);
rise_fall(0, 6, 1);
go(ite_pkg::TRIG_GATED);
chk(run, 0);
rise_fall(1, 4, 1);
rise_fall(0, 5, 0);
@(posedge ref_clk) drv <= 0;
cyc(3);
go(ite_pkg::TRIG_ONESHOT);
chk(run, 1);
close_out();
end
endmodule : input_trigger_expansion_select_bench
